// *** hdl/spm_regs.vh ***
// Constants for the seven-bit port pin multiplexer: register indices,
// reset values and field positions.
// Assumes it is included by bare name from the design files.
`ifndef SPM_REGS_VH
`define SPM_REGS_VH

// ==========================================================================
// Register indices on the plain register port
// ==========================================================================
`define SPM_AW 4
`define SPM_A_PIN_READ 4'h0
`define SPM_A_LATCH 4'h1
`define SPM_A_DIR 4'h2
`define SPM_A_ANA_LOW 4'h3
`define SPM_A_ANA_HIGH 4'h4
`define SPM_A_CMP_STATUS 4'h5
`define SPM_A_CVR_CTRL 4'h6
`define SPM_A_SEG2 4'h7
`define SPM_A_SEG3 4'h8

// ==========================================================================
// Reset values
// ==========================================================================
// Port register resets cover only the seven implemented bits 7 to 1.
`define SPM_RST_LATCH 7'h00
`define SPM_RST_DIR 7'h7f
`define SPM_RST_ANA 8'hff
`define SPM_RST_CVR 8'h00
`define SPM_RST_SEG 8'h00
`define SPM_ZERO8 8'h00
`define SPM_ZERO7 7'h00
`define SPM_ONES7 7'h7f

// ==========================================================================
// Field positions
// ==========================================================================
`define SPM_CVR_OE_BIT 6
`define SPM_CMP2_STAT_BIT 6
`define SPM_CMP1_STAT_BIT 5
`define SPM_PIN_CMP2 1
`define SPM_PIN_CMP1 2
`define SPM_PIN_CHARGE_TIME_MEASUREMENT_UNIT 3
`define SPM_PIN_VREF 5
`define SPM_PIN_SS 7
`define SPM_PIN_CMP2_IN_B 3
`define SPM_PIN_CMP2_IN_A 4
`define SPM_PIN_CMP1_IN_B 5
`define SPM_PIN_CMP1_IN_A 6

// ==========================================================================
// Analog and segment select bits for each pin
// ==========================================================================
`define SPM_ANA_LO_PIN1 6
`define SPM_ANA_LO_PIN2 7
`define SPM_ANA_HI_PIN3 0
`define SPM_ANA_HI_PIN4 1
`define SPM_ANA_HI_PIN5 2
`define SPM_ANA_HI_PIN6 3
`define SPM_ANA_LO_PIN7 5
`define SPM_SEG2_PIN1 3
`define SPM_SEG2_PIN2 4
`define SPM_SEG2_PIN3 5
`define SPM_SEG2_PIN4 6
`define SPM_SEG2_PIN5 7
`define SPM_SEG3_PIN6 0
`define SPM_SEG3_PIN7 1

`endif

// *** hdl/spm_sync.v ***
// Two-flop synchroniser for the seven port pin levels.
// Assumes pins are asynchronous to sys_clk; only the second stage is read.
`timescale 1ns/1ps
`default_nettype none
`include "spm_regs.vh"

module spm_sync (
    input wire sys_clk,
    input wire srst,
    input wire clk_en,
    input wire [7:1] async_in,
    output wire [7:1] sync_out
);

    reg [7:1] stage1_q;
    reg [7:1] stage2_q;

    // ======================================================================
    // Synchroniser stages
    // ======================================================================
    // Each bit passes two flops before any logic sees it.
    always @(posedge sys_clk) begin
        if (srst) begin
            stage1_q <= `SPM_ZERO7;
            stage2_q <= `SPM_ZERO7;
        end else if (clk_en) begin
            stage1_q <= async_in;
            stage2_q <= stage1_q;
        end
    end

    assign sync_out = stage2_q;

endmodule // spm_sync
`default_nettype wire

// *** hdl/spm_port.v ***
// Seven-bit general-purpose port with per-pin function multiplexing.
// Holds the output latch, direction and pin read registers, the analog,
// reference and segment selections, and the fixed-priority pad driver.
// Assumes a plain register port on sys_clk, peripheral signals on sys_clk,
// and asynchronous pad inputs; the analog, comparator, segment and serial
// peripherals sit outside and see only the enables that this block drives.
`timescale 1ns/1ps
`default_nettype none
`include "spm_regs.vh"

module spm_port (
    input wire sys_clk,
    input wire srst,
    input wire clk_en,
    // Register port.
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    // Pads.
    input wire [7:1] pin_in,
    output reg [7:1] pin_out,
    output reg [7:1] pin_oe,
    // Comparator peripheral.
    input wire first_comparator_output,
    input wire second_comparator_output,
    input wire first_comparator_out_en,
    input wire second_comparator_out_en,
    // Charge time measurement unit.
    input wire charge_timing_current_en,
    input wire charge_timing_current_output,
    output reg charge_timing_delay_input,
    // Serial module slave select, active low.
    output reg serial_slave_select_input_n,
    // Peripheral routing enables.
    output reg [7:1] analog_channel_en,
    output reg [7:1] lcd_segment_en,
    output reg comparator_reference_output_en,
    output reg second_comparator_input_b_en,
    output reg second_comparator_input_a_en,
    output reg first_comparator_input_b_en,
    output reg first_comparator_input_a_en
);

    // ======================================================================
    // Register state
    // ======================================================================
    // Port registers hold only the seven implemented bits.
    reg [7:1] latch_q;
    reg [7:1] dir_q;
    reg [7:0] ana_low_q;
    reg [7:0] ana_high_q;
    reg [7:0] cvr_q;
    reg [7:0] seg2_q;
    reg [7:0] seg3_q;
    // Next value of the read data register.
    reg [7:0] reg_rdata_d;

    // Synchronised pad levels and the decoded per-pin selections.
    wire [7:1] pin_sync;
    wire [7:1] ana_sel;
    wire [7:1] seg_sel;
    wire vref_on;
    wire [7:1] blocked;
    wire [7:1] in_ok;
    wire [7:1] din_live;

    // Next values of the pad driver and its loop index.
    reg [7:1] pin_out_d;
    reg [7:1] pin_oe_d;
    integer i;

    // ======================================================================
    // Pad synchroniser
    // ======================================================================
    // Pad levels cross into sys_clk through two flops, so the pin read
    // lags a pad change by two cycles before the read cycle itself.
    spm_sync u_sync (
        .sys_clk(sys_clk),
        .srst(srst),
        .clk_en(clk_en),
        .async_in(pin_in),
        .sync_out(pin_sync)
    );

    // ======================================================================
    // Per-pin selection decode
    // ======================================================================
    // Pins 1 to 6 use channels 6 to 11; pin 7 uses channel 5.
    assign ana_sel[1] = ana_low_q[`SPM_ANA_LO_PIN1];
    assign ana_sel[2] = ana_low_q[`SPM_ANA_LO_PIN2];
    assign ana_sel[3] = ana_high_q[`SPM_ANA_HI_PIN3];
    assign ana_sel[4] = ana_high_q[`SPM_ANA_HI_PIN4];
    assign ana_sel[5] = ana_high_q[`SPM_ANA_HI_PIN5];
    assign ana_sel[6] = ana_high_q[`SPM_ANA_HI_PIN6];
    assign ana_sel[7] = ana_low_q[`SPM_ANA_LO_PIN7];

    // Pins 1 to 5 use segments 19 to 23, pins 6 and 7 segments 24 and 25.
    assign seg_sel[1] = seg2_q[`SPM_SEG2_PIN1];
    assign seg_sel[2] = seg2_q[`SPM_SEG2_PIN2];
    assign seg_sel[3] = seg2_q[`SPM_SEG2_PIN3];
    assign seg_sel[4] = seg2_q[`SPM_SEG2_PIN4];
    assign seg_sel[5] = seg2_q[`SPM_SEG2_PIN5];
    assign seg_sel[6] = seg3_q[`SPM_SEG3_PIN6];
    assign seg_sel[7] = seg3_q[`SPM_SEG3_PIN7];

    // The reference output enable is one bit of the reference control.
    assign vref_on = cvr_q[`SPM_CVR_OE_BIT];

    // Function reports whether a pin is taken away from the digital port.
    // One decode serves the input path, the pad driver and the peripheral
    // enables, so all three agree on when a pin is lost.
    function pin_blocked;
        input integer idx;
        input seg;
        input vref;
        begin
            pin_blocked = seg | (vref & (idx == `SPM_PIN_VREF));
        end
    endfunction

    // A pin is usable as an input when it is one and is not blocked; the
    // digital read also needs the analog selection off.
    genvar g;
    generate
        for (g = 1; g <= 7; g = g + 1) begin : g_pin
            assign blocked[g] = pin_blocked(g, seg_sel[g], vref_on);
            assign in_ok[g] = dir_q[g] & ~blocked[g];
            assign din_live[g] = in_ok[g] & ~ana_sel[g];
        end
    endgenerate

    // ======================================================================
    // Pin driver priority
    // ======================================================================
    // Segment first, reference second, comparator third, charge output fourth, latch last.
    // A blocked pin is released rather than driven low, so a segment or
    // reference voltage on the pad never fights the port driver. The
    // comparator outputs only take over a pin set as output, while the
    // charge output owns pin 3 whatever its direction.
    always @* begin
        pin_out_d = `SPM_ZERO7;
        pin_oe_d = `SPM_ZERO7;
        for (i = 1; i <= 7; i = i + 1) begin
            if (blocked[i]) begin
                pin_oe_d[i] = 1'b0;
            end else if (i == `SPM_PIN_CMP2 && second_comparator_out_en && !dir_q[i]) begin
                pin_oe_d[i] = 1'b1;
                pin_out_d[i] = second_comparator_output;
            end else if (i == `SPM_PIN_CMP1 && first_comparator_out_en && !dir_q[i]) begin
                pin_oe_d[i] = 1'b1;
                pin_out_d[i] = first_comparator_output;
            end else if (i == `SPM_PIN_CHARGE_TIME_MEASUREMENT_UNIT && charge_timing_current_en) begin
                pin_oe_d[i] = 1'b1;
                pin_out_d[i] = charge_timing_current_output;
            end else if (!dir_q[i]) begin
                pin_oe_d[i] = 1'b1;
                pin_out_d[i] = latch_q[i];
            end
        end
    end

    // ======================================================================
    // Register writes
    // ======================================================================
    // Writes to the pin read register land in the output latch.
    // Only bits 7 to 1 of the port registers are kept, so bit 0 can
    // never be set. The comparator status index has no branch here:
    // it is read-only and a write to it is dropped.
    always @(posedge sys_clk) begin
        if (srst) begin
            latch_q <= `SPM_RST_LATCH;
            dir_q <= `SPM_RST_DIR;
            ana_low_q <= `SPM_RST_ANA;
            ana_high_q <= `SPM_RST_ANA;
            cvr_q <= `SPM_RST_CVR;
            seg2_q <= `SPM_RST_SEG;
            seg3_q <= `SPM_RST_SEG;
        end else if (clk_en && reg_wr) begin
            if (reg_addr == `SPM_A_PIN_READ || reg_addr == `SPM_A_LATCH) begin
                latch_q <= reg_wdata[7:1];
            end else if (reg_addr == `SPM_A_DIR) begin
                dir_q <= reg_wdata[7:1];
            end else if (reg_addr == `SPM_A_ANA_LOW) begin
                ana_low_q <= reg_wdata;
            end else if (reg_addr == `SPM_A_ANA_HIGH) begin
                ana_high_q <= reg_wdata;
            end else if (reg_addr == `SPM_A_CVR_CTRL) begin
                cvr_q <= reg_wdata;
            end else if (reg_addr == `SPM_A_SEG2) begin
                seg2_q <= reg_wdata;
            end else if (reg_addr == `SPM_A_SEG3) begin
                seg3_q <= reg_wdata;
            end
        end
    end

    // ======================================================================
    // Register reads
    // ======================================================================
    // Bit 0 of the port registers is unimplemented and reads zero.
    // The pin read is masked by the live-input decode rather than by the
    // direction alone, so an analog or segment pin reads zero even with a
    // high level on its pad.
    always @* begin
        reg_rdata_d = `SPM_ZERO8;
        if (reg_addr == `SPM_A_PIN_READ) begin
            reg_rdata_d = {pin_sync & din_live, 1'b0};
        end else if (reg_addr == `SPM_A_LATCH) begin
            reg_rdata_d = {latch_q, 1'b0};
        end else if (reg_addr == `SPM_A_DIR) begin
            reg_rdata_d = {dir_q, 1'b0};
        end else if (reg_addr == `SPM_A_ANA_LOW) begin
            reg_rdata_d = ana_low_q;
        end else if (reg_addr == `SPM_A_ANA_HIGH) begin
            reg_rdata_d = ana_high_q;
        end else if (reg_addr == `SPM_A_CMP_STATUS) begin
            reg_rdata_d[`SPM_CMP2_STAT_BIT] = second_comparator_output;
            reg_rdata_d[`SPM_CMP1_STAT_BIT] = first_comparator_output;
        end else if (reg_addr == `SPM_A_CVR_CTRL) begin
            reg_rdata_d = cvr_q;
        end else if (reg_addr == `SPM_A_SEG2) begin
            reg_rdata_d = seg2_q;
        end else if (reg_addr == `SPM_A_SEG3) begin
            reg_rdata_d = seg3_q;
        end
    end

    // Read data stand only in the cycle after the strobe.
    // Clearing the data between reads keeps stale values off the bus.
    always @(posedge sys_clk) begin
        if (srst) begin
            reg_rdata <= `SPM_ZERO8;
        end else if (clk_en) begin
            if (reg_rd) begin
                reg_rdata <= reg_rdata_d;
            end else begin
                reg_rdata <= `SPM_ZERO8;
            end
        end
    end

    // ======================================================================
    // Registered pad and peripheral outputs
    // ======================================================================
    // All outputs come from flops; the pads lag the settings by one cycle.
    // The extra cycle is the price of keeping decode glitches off the pads
    // and off the peripheral enables.
    always @(posedge sys_clk) begin
        if (srst) begin
            // Pads released and every pin an analog input after reset.
            pin_out <= `SPM_ZERO7;
            pin_oe <= `SPM_ZERO7;
            charge_timing_delay_input <= 1'b0;
            serial_slave_select_input_n <= 1'b1;
            analog_channel_en <= `SPM_ONES7;
            lcd_segment_en <= `SPM_ZERO7;
            comparator_reference_output_en <= 1'b0;
            second_comparator_input_b_en <= 1'b0;
            second_comparator_input_a_en <= 1'b0;
            first_comparator_input_b_en <= 1'b0;
            first_comparator_input_a_en <= 1'b0;
        end else if (clk_en) begin
            pin_out <= pin_out_d;
            pin_oe <= pin_oe_d;
            // Analog selection stays active beside a driven output.
            analog_channel_en <= ana_sel & ~blocked;
            lcd_segment_en <= seg_sel;
            comparator_reference_output_en <= vref_on & ~seg_sel[`SPM_PIN_VREF];
            // Pulse delay input follows pin 1 while it is an input.
            charge_timing_delay_input <= pin_sync[`SPM_PIN_CMP2] &
                dir_q[`SPM_PIN_CMP2] & ~blocked[`SPM_PIN_CMP2];
            // Slave select sees pin 7 only as an input; idle is high.
            if (dir_q[`SPM_PIN_SS] && !blocked[`SPM_PIN_SS]) begin
                serial_slave_select_input_n <= pin_sync[`SPM_PIN_SS];
            end else begin
                serial_slave_select_input_n <= 1'b1;
            end
            // Comparator analog inputs need the pin as input. The analog
            // selection is not masked here, as these inputs use that path.
            second_comparator_input_b_en <= in_ok[`SPM_PIN_CMP2_IN_B];
            second_comparator_input_a_en <= in_ok[`SPM_PIN_CMP2_IN_A];
            first_comparator_input_b_en <= in_ok[`SPM_PIN_CMP1_IN_B];
            first_comparator_input_a_en <= in_ok[`SPM_PIN_CMP1_IN_A];
        end
    end

endmodule // spm_port
`default_nettype wire

// *** tb/spm_board.sv ***
// Board model for the seven port pads.
// Assumes the testbench sets ext_lvl as the board's own pin levels.
`timescale 1ns/1ps
`default_nettype none
module spm_board (
    input wire logic [7:1] pin_out,
    input wire logic [7:1] pin_oe,
    input wire logic [7:1] ext_lvl,
    output logic [7:1] pin_in
);
    // A pad shows the device's drive while enabled, else the board level.
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule // spm_board
`default_nettype wire

// *** tb/spm_port_props.sv ***
// Checker for the pad and register outputs of the port multiplexer.
// Assumes it is bound to spm_port and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module spm_port_props (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic reg_rd,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_rdata,
    input wire logic [7:1] pin_out,
    input wire logic [7:1] pin_oe,
    input wire logic first_comparator_output,
    input wire logic second_comparator_output,
    input wire logic first_comparator_out_en,
    input wire logic second_comparator_out_en,
    input wire logic charge_timing_current_en,
    input wire logic charge_timing_current_output,
    input wire logic serial_slave_select_input_n,
    input wire logic [7:1] analog_channel_en,
    input wire logic [7:1] lcd_segment_en,
    input wire logic comparator_reference_output_en,
    input wire logic first_comparator_input_a_en
);
    // ========================================
    // Properties
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    // Register reads, reset state and pad overrides.
    AST_BIT0_ZERO: assert property (reg_rd && reg_addr <= 4'h2 |=> !reg_rdata[0])
        else $error("bit 0 read as one");
    AST_RESET_ANALOG: assert property ($past(srst) |-> analog_channel_en == 7'h7f && pin_oe == 7'h00)
        else $error("pins not analog inputs after reset");
    AST_SEG_BLOCKS: assert property ((lcd_segment_en & $past(lcd_segment_en) & (pin_oe | analog_channel_en)) == 7'h00)
        else $error("segment pin still used");
    AST_VREF_BLOCKS: assert property (comparator_reference_output_en && $past(comparator_reference_output_en) |-> !pin_oe[5] && !analog_channel_en[5])
        else $error("pin 5 digital with reference on");
    AST_CMP2_PIN1: assert property (pin_oe[1] && $past(second_comparator_out_en) |-> pin_out[1] == $past(second_comparator_output))
        else $error("pin 1 not comparator output");
    AST_CMP1_PIN2: assert property (pin_oe[2] && $past(first_comparator_out_en) |-> pin_out[2] == $past(first_comparator_output))
        else $error("pin 2 not comparator output");
    AST_CHARGE_TIME_MEASUREMENT_UNIT_PIN3: assert property (pin_oe[3] && $past(charge_timing_current_en) |-> pin_out[3] == $past(charge_timing_current_output))
        else $error("pin 3 not charge output");
    AST_SS_INPUT: assert property (!serial_slave_select_input_n |-> !pin_oe[7] && !lcd_segment_en[7])
        else $error("select active on non-input pin");
    AST_CMPIN_INPUT: assert property (first_comparator_input_a_en |-> !pin_oe[6])
        else $error("comparator input on driven pin");
endmodule // spm_port_props
bind spm_port spm_port_props chk (.sys_clk(sys_clk), .srst(srst), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_rdata(reg_rdata), .pin_out(pin_out), .pin_oe(pin_oe),
    .first_comparator_output(first_comparator_output),
    .second_comparator_output(second_comparator_output),
    .first_comparator_out_en(first_comparator_out_en),
    .second_comparator_out_en(second_comparator_out_en),
    .charge_timing_current_en(charge_timing_current_en),
    .charge_timing_current_output(charge_timing_current_output),
    .serial_slave_select_input_n(serial_slave_select_input_n),
    .analog_channel_en(analog_channel_en), .lcd_segment_en(lcd_segment_en),
    .comparator_reference_output_en(comparator_reference_output_en),
    .first_comparator_input_a_en(first_comparator_input_a_en));
`default_nettype wire

// *** tb/spm_port_tb.sv ***
// Self-checking testbench for the seven-bit port pin multiplexer.
// Assumes the board model and the checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "spm_regs.vh"
module spm_port_tb;
    // ========================================
    // Signals
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, ce = 1'b1;
    logic c1 = 1'b0, c2 = 1'b0, e1 = 1'b0, e2 = 1'b0, te = 1'b0, tv = 1'b0;
    logic [3:0] ad = 4'h0;
    logic [7:0] wd = 8'h00;
    logic [7:1] ext = 7'h00;
    wire [7:1] pin, po, poe, ace, lse;
    wire [7:0] rdq;
    wire cti, ss_n, vre, ib2, ia2, ib1, ia1;
    int err_total = 0;
    int num_checks = 0;
    // The clock toggles every half period.
    always #4 clk = ~clk;
    // Device and board; the run enable drops only in the freeze scenario.
    spm_port dut (.sys_clk(clk), .srst(rst), .clk_en(ce), .reg_addr(ad), .reg_wdata(wd),
        .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdq), .pin_in(pin), .pin_out(po), .pin_oe(poe),
        .first_comparator_output(c1), .second_comparator_output(c2),
        .first_comparator_out_en(e1), .second_comparator_out_en(e2),
        .charge_timing_current_en(te), .charge_timing_current_output(tv),
        .charge_timing_delay_input(cti), .serial_slave_select_input_n(ss_n),
        .analog_channel_en(ace), .lcd_segment_en(lse), .comparator_reference_output_en(vre),
        .second_comparator_input_b_en(ib2), .second_comparator_input_a_en(ia2),
        .first_comparator_input_b_en(ib1), .first_comparator_input_a_en(ia1));
    spm_board bd (.pin_out(po), .pin_oe(poe), .ext_lvl(ext), .pin_in(pin));
    // ========================================
    // Shared tasks
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("FAIL %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wreg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        ad <= a;
        wd <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rchk(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        rd <= 1'b1;
        ad <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdq, e);
    endtask
    task automatic final_report;
        if (err_total == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // ========================================
    // Scenarios
    task automatic t_reset;
        chk({1'b0, ace}, 8'h7f);
        chk({1'b0, poe}, 8'h00);
        rchk(`SPM_A_PIN_READ, 8'h00);
        rchk(`SPM_A_DIR, 8'hfe);
        rchk(`SPM_A_ANA_LOW, 8'hff);
        rchk(`SPM_A_ANA_HIGH, 8'hff);
        rchk(`SPM_A_LATCH, 8'h00);
        rchk(`SPM_A_SEG2, 8'h00);
        rchk(`SPM_A_SEG3, 8'h00);
        rchk(`SPM_A_CVR_CTRL, 8'h00);
    endtask
    task automatic t_bits;
        wreg(`SPM_A_LATCH, 8'hff);
        rchk(`SPM_A_LATCH, 8'hfe);
        wreg(`SPM_A_PIN_READ, 8'h81);
        rchk(`SPM_A_LATCH, 8'h80);
        wreg(`SPM_A_DIR, 8'h01);
        rchk(`SPM_A_DIR, 8'h00);
        wreg(4'h9, 8'h55);
        rchk(4'h9, 8'h00);
    endtask
    task automatic t_out;
        wreg(`SPM_A_LATCH, 8'haa);
        cyc(2);
        chk({1'b0, po}, 8'h55);
        chk({1'b0, poe}, 8'h7f);
        chk({1'b0, ace}, 8'h7f);
    endtask
    task automatic t_in;
        ext <= 7'h35;
        wreg(`SPM_A_DIR, 8'hfe);
        wreg(`SPM_A_ANA_LOW, 8'h00);
        wreg(`SPM_A_ANA_HIGH, 8'h00);
        cyc(4);
        rchk(`SPM_A_PIN_READ, 8'h6a);
        chk({7'h00, ss_n}, 8'h00);
        chk({6'h00, cti, ia1}, 8'h03);
        wreg(`SPM_A_ANA_LOW, 8'h40);
        cyc(2);
        rchk(`SPM_A_PIN_READ, 8'h68);
        chk({4'h0, ib2, ia2, ib1, ia1}, 8'h0f);
        wreg(`SPM_A_ANA_LOW, 8'h60);
        wreg(`SPM_A_ANA_HIGH, 8'h09);
        cyc(2);
        chk({1'b0, ace}, 8'h65);
        wreg(`SPM_A_ANA_LOW, 8'h40);
        wreg(`SPM_A_ANA_HIGH, 8'h00);
    endtask
    task automatic t_cmp;
        wreg(`SPM_A_DIR, 8'h00);
        wreg(`SPM_A_LATCH, 8'h04);
        @(posedge clk);
        e1 <= 1'b1;
        e2 <= 1'b1;
        c2 <= 1'b1;
        cyc(2);
        chk({6'h00, po[2:1]}, 8'h01);
        rchk(`SPM_A_CMP_STATUS, 8'h40);
        @(posedge clk);
        c1 <= 1'b1;
        c2 <= 1'b0;
        cyc(2);
        chk({6'h00, po[2:1]}, 8'h02);
        wreg(`SPM_A_CMP_STATUS, 8'h00);
        rchk(`SPM_A_CMP_STATUS, 8'h20);
    endtask
    task automatic t_seg;
        wreg(`SPM_A_SEG2, 8'hf8);
        wreg(`SPM_A_SEG3, 8'h03);
        cyc(2);
        chk({1'b0, poe}, 8'h00);
        chk({1'b0, lse}, 8'h7f);
        chk({ace, ss_n}, 8'h01);
        wreg(`SPM_A_SEG2, 8'h00);
        wreg(`SPM_A_SEG3, 8'h00);
        @(posedge clk);
        e1 <= 1'b0;
        e2 <= 1'b0;
    endtask
    task automatic t_vref;
        wreg(`SPM_A_CVR_CTRL, 8'h40);
        cyc(2);
        chk({vre, poe}, 8'hef);
        wreg(`SPM_A_DIR, 8'hfe);
        cyc(4);
        chk({4'h0, ib2, ia2, ib1, ia1}, 8'h0d);
        rchk(`SPM_A_PIN_READ, 8'h48);
    endtask
    task automatic t_charge_time_measurement_unit;
        @(posedge clk);
        te <= 1'b1;
        tv <= 1'b1;
        cyc(2);
        chk({6'h00, poe[3], po[3]}, 8'h03);
    endtask
    task automatic t_freeze;
        @(posedge clk);
        ce <= 1'b0;
        wreg(`SPM_A_LATCH, 8'hfe);
        @(posedge clk);
        ce <= 1'b1;
        rchk(`SPM_A_LATCH, 8'h04);
    endtask
    // Reset for 20 cycles, then run each scenario in turn.
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        #1;
        t_reset();
        t_bits();
        t_out();
        t_in();
        t_cmp();
        t_seg();
        t_vref();
        t_charge_time_measurement_unit();
        t_freeze();
        final_report();
    end
endmodule // spm_port_tb
`default_nettype wire
